// ==== hdl/plc_cmd_core.sv ====
// pin and file lifecycle command handler with axi4-lite register access
// Summary of operation
// - refuse enable when pin enabled or blocked
// - enable match: counter to 3, enabled
// - enable mismatch: decrement counter, stay disabled; the blocking one takes enable from ctrl bit 3
// - third mismatch blocks; only unblock clears
// - blocked and disabled: access stays granted
// - blocked and enabled: access never granted
// - enable clears alternative key usage to 00
// - successful enable triggers environment re-evaluation
// - good unblock: new pin, counters reset, enabled
// - new pin valid on all channels
// - bad unblock: shared counter down, pin untouched
// - tenth bad unblock blocks, answers 63C0
// - unblock on blocked code answers 6983
// - empty unblock returns 63CX remaining tries
// - failed unblock reports 63CX remaining tries
// - deactivate only with access condition, update flag
// - success sets current file; failure keeps selection
// - deactivated file rejects all but select, activate; the code refuses only commands of the default branch, with lc 00
// - p1 selects target mode; p2 must be 00
// - p1 p2 00 and no data: current file
// - activate only with access condition, update flag
// - p2 bit8 scope, bits7-6 zero, ref 01-1F
//
// Local design decisions: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module plc_cmd_core #(
  parameter int NUM_PINS = 2,
  parameter int NUM_FILES = 8
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // command request
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire logic [2:0] cmd_code,
  input wire logic [7:0] cmd_p1,
  input wire logic [7:0] cmd_p2,
  input wire logic [7:0] cmd_lc,
  input wire logic [127:0] cmd_data,
  input wire logic [15:0] cmd_file_id,
  // command answer
  output logic rsp_valid,
  output logic [15:0] rsp_sw,
  output logic se_revalidate,
  output logic [NUM_PINS-1:0] pin_access_ok,
  output logic [15:0] cur_ef,
  // axi4-lite slave
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  localparam int PW = $clog2(NUM_PINS);
  localparam int FW = $clog2(NUM_FILES);
  // file status word holds at most 16 deactivation flags
  if (NUM_PINS < 2 || NUM_PINS > 31 || NUM_FILES < 2 || NUM_FILES > 16)
  begin
    $error("plc_cmd_core: unsupported parameters");
  end

  ////////////////////////////////////////////////////////////////////////////
  // state
  plc_pkg::plc_state_t state_q;
  logic [63:0] pin_val_q [NUM_PINS];
  logic [63:0] unblk_val_q [NUM_PINS];
  logic [3:0] pin_tries_q [NUM_PINS];
  logic [3:0] unblk_tries_q [NUM_PINS];
  logic [NUM_PINS-1:0] pin_en_q;
  logic [NUM_PINS-1:0] pin_blk_q;
  logic [NUM_PINS-1:0] unblk_blk_q;
  logic [7:0] alt_usage_q;
  logic [NUM_FILES-1:0] file_deact_q;
  logic [15:0] file_id_q [NUM_FILES];
  logic [15:0] cur_ef_q;
  logic [31:0] ctrl_q;
  logic [15:0] sw_q;
  logic rsp_q;
  logic reval_q;
  logic [2:0] c_code_q;
  logic [7:0] c_p1_q, c_p2_q, c_lc_q;
  logic [127:0] c_data_q;
  logic [15:0] c_fid_q;

  function automatic logic [15:0] retry_sw(input logic [3:0] n);
    retry_sw = plc_pkg::SW_RETRY_BASE | {12'h000, n};
  endfunction

  function automatic logic p2_ok(input logic [7:0] p2);
    p2_ok = (p2[6:5] == 2'b00) && (p2[4:0] != 5'h00);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // decode of the latched command
  logic [PW-1:0] pidx;
  logic pidx_ok;
  logic [15:0] tgt_fid;
  logic [FW:0] fhit;
  always_comb
  begin
    pidx = c_p2_q[PW-1:0];
    pidx_ok = p2_ok(c_p2_q) && ({27'h0, c_p2_q[4:0]} < NUM_PINS);
    // path target: file id from cmd_file_id, or the current file when lc is 00
    tgt_fid = (c_lc_q == 8'h00) ? cur_ef_q : c_fid_q;
    fhit = NUM_FILES[FW:0];
    for (int i = NUM_FILES - 1; i >= 0; i--)
    begin
      if (file_id_q[i] == tgt_fid)
        fhit = i[FW:0];
    end
  end
  logic [63:0] pin_in;
  logic [63:0] new_pin;
  assign pin_in = c_data_q[127:64];
  assign new_pin = c_data_q[63:0];

  assign cmd_ready = (state_q == plc_pkg::ST_IDLE);
  assign rsp_valid = rsp_q;
  assign rsp_sw = sw_q;
  assign se_revalidate = reval_q;
  assign cur_ef = cur_ef_q;
  always_comb
  begin
    for (int i = 0; i < NUM_PINS; i++)
      pin_access_ok[i] = !pin_en_q[i];
  end

  ////////////////////////////////////////////////////////////////////////////
  // axi4-lite slave
  logic aw_q, w_q;
  logic [7:0] awaddr_q;
  logic [31:0] wdata_q;
  assign s_axi_awready = !aw_q && !s_axi_bvalid;
  assign s_axi_wready = !w_q && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  logic wr_go;
  assign wr_go = aw_q && w_q && !s_axi_bvalid;
  logic ld_pin, ld_hi;
  assign ld_pin = wr_go && awaddr_q == plc_pkg::REG_PIN_LOAD;
  assign ld_hi = wr_go && awaddr_q == plc_pkg::REG_PIN_LOAD_HI;
  logic [31:0] ld_lo_q;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_q <= 1'b0;
      w_q <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_q <= 32'h0000_0000;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= plc_pkg::RESP_OKAY;
      ctrl_q <= plc_pkg::CTRL_RESET;
      ld_lo_q <= 32'h0000_0000;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_q <= 1'b1;
        wdata_q <= s_axi_wdata;
      end
      if (wr_go)
      begin
        aw_q <= 1'b0;
        w_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= plc_pkg::RESP_OKAY;
        if (awaddr_q == plc_pkg::REG_CTRL)
          ctrl_q <= wdata_q;
        else if (awaddr_q == plc_pkg::REG_PIN_LOAD)
          ld_lo_q <= wdata_q;
        else if (ld_hi)
          ld_lo_q <= ld_lo_q;
        else
          s_axi_bresp <= plc_pkg::RESP_SLVERR;
      end
      else if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  logic [PW-1:0] sel_pin;
  assign sel_pin = ctrl_q[8 +: PW];
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= plc_pkg::RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= plc_pkg::RESP_OKAY;
      if (s_axi_araddr == plc_pkg::REG_CTRL)
        s_axi_rdata <= ctrl_q;
      else if (s_axi_araddr == plc_pkg::REG_PIN_STAT)
        s_axi_rdata <= {16'h0000, alt_usage_q, 2'b00, pin_en_q[sel_pin],
          pin_blk_q[sel_pin], pin_tries_q[sel_pin]};
      else if (s_axi_araddr == plc_pkg::REG_UNBLK_STAT)
        s_axi_rdata <= {27'h0, unblk_blk_q[sel_pin], unblk_tries_q[sel_pin]};
      else if (s_axi_araddr == plc_pkg::REG_FILE_STAT)
        s_axi_rdata <= {cur_ef_q, {(16-NUM_FILES%17){1'b0}},
          file_deact_q[NUM_FILES-1:0]};
      else if (s_axi_araddr == plc_pkg::REG_LAST_SW)
        s_axi_rdata <= {16'h0000, sw_q};
      else
      begin
        s_axi_rdata <= 32'h0000_0000;
        s_axi_rresp <= plc_pkg::RESP_SLVERR;
      end
    end
    else if (s_axi_rvalid && s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // command sequencing: take, execute one cycle, answer one cycle
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state_q <= plc_pkg::ST_IDLE;
      c_code_q <= 3'h0;
      c_p1_q <= 8'h00;
      c_p2_q <= 8'h00;
      c_lc_q <= 8'h00;
      c_data_q <= 128'h0;
      c_fid_q <= 16'h0000;
    end
    else
    begin
      case (state_q)
        plc_pkg::ST_IDLE:
        begin
          if (cmd_valid)
          begin
            state_q <= plc_pkg::ST_EXEC;
            c_code_q <= cmd_code;
            c_p1_q <= cmd_p1;
            c_p2_q <= cmd_p2;
            c_lc_q <= cmd_lc;
            c_data_q <= cmd_data;
            c_fid_q <= cmd_file_id;
          end
        end
        plc_pkg::ST_EXEC: state_q <= plc_pkg::ST_DONE;
        default: state_q <= plc_pkg::ST_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin and unblock-code state
  logic exec;
  assign exec = (state_q == plc_pkg::ST_EXEC);
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rsp_q <= 1'b0;
      reval_q <= 1'b0;
      sw_q <= plc_pkg::SW_OK;
      alt_usage_q <= plc_pkg::USAGE_USE;
      pin_en_q <= '1;
      pin_blk_q <= '0;
      unblk_blk_q <= '0;
      file_deact_q <= '0;
      cur_ef_q <= 16'h0000;
      for (int i = 0; i < NUM_PINS; i++)
      begin
        pin_val_q[i] <= 64'h0;
        unblk_val_q[i] <= 64'h0;
        pin_tries_q[i] <= plc_pkg::PIN_TRIES_INIT;
        unblk_tries_q[i] <= plc_pkg::UNBLK_TRIES_INIT;
      end
      for (int f = 0; f < NUM_FILES; f++)
        file_id_q[f] <= 16'h2F00 + 16'(f);
    end
    else
    begin
      rsp_q <= exec;
      reval_q <= 1'b0;
      if (ld_hi)
        if (ctrl_q[plc_pkg::CTRL_PIN_BIT])
          pin_val_q[sel_pin] <= {wdata_q, ld_lo_q};
        else
          unblk_val_q[sel_pin] <= {wdata_q, ld_lo_q};
      // a freshly loaded pin starts enabled or disabled as bit 0 asks
      if (ld_hi && ctrl_q[plc_pkg::CTRL_PIN_BIT])
        pin_en_q[sel_pin] <= ctrl_q[plc_pkg::CTRL_SEL_BIT];
      if (exec)
      begin
        // any refusal keeps all state
        case (c_code_q)
          plc_pkg::CMD_ENABLE_PIN:
          begin
            if (c_p1_q != 8'h00 || !pidx_ok)
              sw_q <= plc_pkg::SW_BAD_P1P2;
            else if (c_lc_q != plc_pkg::LEN_PIN)
              sw_q <= plc_pkg::SW_BAD_LEN;
            else if (pin_en_q[pidx] || pin_blk_q[pidx])
              sw_q <= plc_pkg::SW_COND_NOT_MET;
            else if (c_data_q[127:64] == pin_val_q[pidx])
            begin
              pin_tries_q[pidx] <= plc_pkg::PIN_TRIES_INIT;
              pin_en_q[pidx] <= 1'b1;
              alt_usage_q <= plc_pkg::USAGE_DONT_USE;
              reval_q <= 1'b1;
              sw_q <= plc_pkg::SW_OK;
            end
            else
            begin
              pin_tries_q[pidx] <= pin_tries_q[pidx] - 4'h1;
              sw_q <= retry_sw(pin_tries_q[pidx] - 4'h1);
              if (pin_tries_q[pidx] == 4'h1)
              begin
                pin_blk_q[pidx] <= 1'b1;
                pin_en_q[pidx] <= ctrl_q[plc_pkg::CTRL_BLK_EN_BIT];
              end
            end
          end
          plc_pkg::CMD_UNBLOCK_PIN:
          begin
            if (c_p1_q != 8'h00 || !pidx_ok)
              sw_q <= plc_pkg::SW_BAD_P1P2;
            else if (unblk_blk_q[pidx])
              sw_q <= plc_pkg::SW_BLOCKED;
            else if (c_lc_q == 8'h00)
              sw_q <= retry_sw(unblk_tries_q[pidx]);
            else if (c_lc_q != plc_pkg::LEN_UNBLOCK)
              sw_q <= plc_pkg::SW_BAD_LEN;
            else if (pin_in == unblk_val_q[pidx])
            begin
              pin_val_q[pidx] <= new_pin;
              unblk_tries_q[pidx] <= plc_pkg::UNBLK_TRIES_INIT;
              pin_tries_q[pidx] <= plc_pkg::PIN_TRIES_INIT;
              pin_en_q[pidx] <= 1'b1;
              pin_blk_q[pidx] <= 1'b0;
              sw_q <= plc_pkg::SW_OK;
            end
            else
            begin
              // shared counter, pin itself untouched
              unblk_tries_q[pidx] <= unblk_tries_q[pidx] - 4'h1;
              sw_q <= retry_sw(unblk_tries_q[pidx] - 4'h1);
              if (unblk_tries_q[pidx] == 4'h1)
                unblk_blk_q[pidx] <= 1'b1;
            end
          end
          plc_pkg::CMD_DEACTIVATE, plc_pkg::CMD_ACTIVATE:
          begin
            if (c_p2_q != 8'h00 || (c_p1_q != plc_pkg::SEL_BY_FID &&
                c_p1_q != plc_pkg::SEL_PATH_MF &&
                c_p1_q != plc_pkg::SEL_PATH_DF))
              sw_q <= plc_pkg::SW_BAD_P1P2;
            else if (fhit == NUM_FILES[FW:0])
              sw_q <= plc_pkg::SW_UNMAPPED;
            else if (c_code_q == plc_pkg::CMD_DEACTIVATE &&
                !ctrl_q[plc_pkg::CTRL_DEACT_AC_BIT])
              sw_q <= plc_pkg::SW_SEC_NOT_MET;
            else if (c_code_q == plc_pkg::CMD_ACTIVATE &&
                !ctrl_q[plc_pkg::CTRL_ACT_AC_BIT])
              sw_q <= plc_pkg::SW_SEC_NOT_MET;
            else
            begin
              file_deact_q[fhit[FW-1:0]] <=
                (c_code_q == plc_pkg::CMD_DEACTIVATE);
              cur_ef_q <= tgt_fid;
              sw_q <= plc_pkg::SW_OK;
            end
          end
          default:
          begin
            // other commands with lc 00 refused while the current file is deactivated
            if (fhit != NUM_FILES[FW:0] && c_lc_q == 8'h00 &&
                file_deact_q[fhit[FW-1:0]])
              sw_q <= plc_pkg::SW_FILE_INVALID;
            else
              sw_q <= plc_pkg::SW_OK;
          end
        endcase
      end
    end
  end
endmodule
`default_nettype wire

// ==== hdl/plc_pkg.sv ====
// package for the pin and file lifecycle command handler
package plc_pkg;
  // command codes on the user-side command port
  typedef enum logic [2:0] {
    CMD_ENABLE_PIN = 3'b001,
    CMD_UNBLOCK_PIN = 3'b010,
    CMD_DEACTIVATE = 3'b011,
    CMD_ACTIVATE = 3'b100,
    CMD_OTHER = 3'b101
  } plc_cmd_t;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_EXEC = 2'b01,
    ST_DONE = 2'b10
  } plc_state_t;
  // retry counter initial values
  localparam logic [3:0] PIN_TRIES_INIT = 4'h3;
  localparam logic [3:0] UNBLK_TRIES_INIT = 4'hA;
  // status words
  localparam logic [15:0] SW_OK = 16'h9000;
  localparam logic [15:0] SW_RETRY_BASE = 16'h63C0;
  localparam logic [15:0] SW_BLOCKED = 16'h6983;
  localparam logic [15:0] SW_COND_NOT_MET = 16'h6985;
  localparam logic [15:0] SW_SEC_NOT_MET = 16'h6982;
  localparam logic [15:0] SW_BAD_P1P2 = 16'h6B00;
  localparam logic [15:0] SW_BAD_LEN = 16'h6700;
  localparam logic [15:0] SW_FILE_INVALID = 16'h6283;
  localparam logic [15:0] SW_UNMAPPED = 16'h6A82;
  // selection control codes in parameter byte one
  localparam logic [7:0] SEL_BY_FID = 8'h00;
  localparam logic [7:0] SEL_PATH_MF = 8'h08;
  localparam logic [7:0] SEL_PATH_DF = 8'h09;
  // usage qualifier values of the pin status object
  localparam logic [7:0] USAGE_DONT_USE = 8'h00;
  localparam logic [7:0] USAGE_USE = 8'h08;
  // lengths
  localparam logic [7:0] LEN_PIN = 8'h08;
  localparam logic [7:0] LEN_UNBLOCK = 8'h10;
  // axi register offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_PIN_STAT = 8'h04;
  localparam logic [7:0] REG_UNBLK_STAT = 8'h08;
  localparam logic [7:0] REG_FILE_STAT = 8'h0C;
  localparam logic [7:0] REG_LAST_SW = 8'h10;
  localparam logic [7:0] REG_PIN_LOAD = 8'h14;
  localparam logic [7:0] REG_PIN_LOAD_HI = 8'h18;
  // ctrl register fields
  localparam int CTRL_SEL_BIT = 0;
  localparam int CTRL_PIN_BIT = 1;
  localparam int CTRL_ALT_BIT = 2;
  localparam int CTRL_BLK_EN_BIT = 3;
  localparam int CTRL_DEACT_AC_BIT = 4;
  localparam int CTRL_ACT_AC_BIT = 5;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0030;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage

// ==== verification/pin_and_file_lifecycle_cmds_tb.sv ====
// self-checking bench of the pin and file lifecycle command handler
`timescale 1ns/1ps
`default_nettype none
module pin_and_file_lifecycle_cmds_tb;
  logic aclk = 1'h0;
  logic aresetn = 1'h0;
  logic cmd_valid, cmd_ready, rsp_valid, se_revalidate;
  logic [2:0] cmd_code;
  logic [7:0] cmd_p1, cmd_p2, cmd_lc;
  logic [127:0] cmd_data;
  logic [15:0] cmd_file_id, rsp_sw, cur_ef;
  logic [1:0] pin_access_ok, s_axi_bresp, s_axi_rresp;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [31:0] sq[$];
  logic [33:0] rq[$];
  int num_errors = 0;
  int n_tests = 0;
  logic [31:0] seed = 32'h0001_691E;
  logic [7:0] modes [3] = '{plc_pkg::SEL_BY_FID, plc_pkg::SEL_PATH_MF,
    plc_pkg::SEL_PATH_DF};
  int k;
  always #2 aclk = ~aclk;
  plc_term term (.aclk, .cmd_valid, .cmd_ready, .cmd_code, .cmd_p1, .cmd_p2,
    .cmd_lc, .cmd_data, .cmd_file_id);
  plc_cmd_core #(.NUM_PINS(2), .NUM_FILES(8)) dut (.aclk, .aresetn,
    .cmd_valid, .cmd_ready, .cmd_code, .cmd_p1, .cmd_p2, .cmd_lc, .cmd_data,
    .cmd_file_id, .rsp_valid, .rsp_sw, .se_revalidate, .pin_access_ok,
    .cur_ef, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task automatic close_out();
    $display("mismatches %0d, checks %0d", num_errors, n_tests);
    if (num_errors == 0 && n_tests > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic bad(input string m);
    num_errors++;
    $display("wrong value at %0t: %s", $time, m);
  endtask
  task automatic hang();
    bad("no answer in time");
    close_out();
  endtask
  task automatic chk_sw(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) bad($sformatf("status/file %h, want %h", got, exp));
  endtask
  task automatic chk_bus(input logic [33:0] got, input logic [33:0] exp);
    n_tests++;
    if (got !== exp) bad($sformatf("bus %h, want %h", got, exp));
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic cmd(input logic [2:0] c, input logic [7:0] p1, p2, lc,
    input logic [127:0] d, input logic [15:0] fid, sw, ef);
    bit ok;
    sq.push_back({sw, ef});
    term.send(c, p1, p2, lc, d, fid, int'(xs() & 32'h3), ok);
    if (!ok) hang();
    repeat (3) @(posedge aclk);
  endtask
  task automatic axw(input logic [7:0] a, input logic [31:0] d,
    input logic [1:0] e);
    int i;
    rq.push_back({e, 32'h0});
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    for (i = 0; i < 30; i++)
    begin
      @(posedge aclk);
      if (s_axi_awready === 1'h1) s_axi_awvalid <= 1'h0;
      if (s_axi_wready === 1'h1) s_axi_wvalid <= 1'h0;
      if (s_axi_bvalid === 1'h1) break;
    end
    s_axi_bready <= 1'h0;
    if (i == 30) hang();
  endtask
  task automatic axr(input logic [7:0] a, input logic [33:0] e);
    int i;
    rq.push_back(e);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    for (i = 0; i < 30; i++)
    begin
      @(posedge aclk);
      if (s_axi_arready === 1'h1) s_axi_arvalid <= 1'h0;
      if (s_axi_rvalid === 1'h1) break;
    end
    s_axi_rready <= 1'h0;
    if (i == 30) hang();
  endtask
  // results are paired with the oldest pending note
  always @(posedge aclk)
  begin
    if (aresetn && rsp_valid === 1'h1)
      chk_sw({rsp_sw, cur_ef}, sq.size() ? sq.pop_front() : 32'hX);
    if (aresetn && s_axi_bvalid === 1'h1 && s_axi_bready === 1'h1)
      chk_bus({s_axi_bresp, 32'h0}, rq.size() ? rq.pop_front() : 34'hX);
    if (aresetn && s_axi_rvalid === 1'h1 && s_axi_rready === 1'h1)
      chk_bus({s_axi_rresp, s_axi_rdata}, rq.size() ? rq.pop_front() : 34'hX);
  end
  initial
  begin
    repeat (20000) @(posedge aclk);
    hang();
  end
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (10) @(posedge aclk);
    aresetn <= 1'h1;
    axr(plc_pkg::REG_CTRL, {2'h0, plc_pkg::CTRL_RESET});
    axw(plc_pkg::REG_CTRL, 32'h0000_0130, plc_pkg::RESP_OKAY);
    axr(plc_pkg::REG_PIN_STAT, {2'h0, 32'h0000_0823});
    axr(8'h40, {plc_pkg::RESP_SLVERR, 32'h0});
    axw(8'h40, xs(), plc_pkg::RESP_SLVERR);
    cmd(plc_pkg::CMD_ENABLE_PIN, 8'h00, 8'h01, 8'h08, {xs(), xs(), 64'h0},
      16'h0000, plc_pkg::SW_COND_NOT_MET, 16'h0000);
    axr(plc_pkg::REG_PIN_STAT, {2'h0, 32'h0000_0823});
    axw(plc_pkg::REG_CTRL, 32'h0000_013A, plc_pkg::RESP_OKAY);
    axw(plc_pkg::REG_PIN_LOAD_HI, 32'h66, plc_pkg::RESP_OKAY);
    chk_sw({30'h0, pin_access_ok}, 32'h2);
    cmd(plc_pkg::CMD_ENABLE_PIN, 8'h00, 8'h01, 8'h08, {32'h66, 96'h0},
      16'h0000, plc_pkg::SW_OK, 16'h0000);
    axr(plc_pkg::REG_PIN_STAT, {2'h0, 32'h0000_0023});
    axw(plc_pkg::REG_PIN_LOAD_HI, 32'h66, plc_pkg::RESP_OKAY);
    for (k = 2; k >= 0; k--)
      cmd(plc_pkg::CMD_ENABLE_PIN, 8'h00, 8'h01, 8'h08, 128'h0, 16'h0000,
        16'h63C0 | 16'(k), 16'h0000);
    axr(plc_pkg::REG_PIN_STAT, {2'h0, 32'h0000_0030});
    chk_sw({30'h0, pin_access_ok}, 32'h0);
    cmd(plc_pkg::CMD_ENABLE_PIN, 8'h00, 8'h01, 8'h08, 128'h0, 16'h0000,
      plc_pkg::SW_COND_NOT_MET, 16'h0000);
    cmd(plc_pkg::CMD_UNBLOCK_PIN, 8'h00, 8'h01, 8'h00, 128'h0, 16'h0000,
      16'h63CA, 16'h0000);
    cmd(plc_pkg::CMD_UNBLOCK_PIN, 8'h00, 8'h01, 8'h10,
      {xs() | 32'h1, xs(), xs(), xs()}, 16'h0000, 16'h63C9,
      16'h0000);
    axr(plc_pkg::REG_PIN_STAT, {2'h0, 32'h0000_0030});
    cmd(plc_pkg::CMD_UNBLOCK_PIN, 8'h00, 8'h01, 8'h10, {64'h0, xs(), xs()},
      16'h0000, plc_pkg::SW_OK, 16'h0000);
    axr(plc_pkg::REG_UNBLK_STAT, {2'h0, 32'h0000_000A});
    axr(plc_pkg::REG_PIN_STAT, {2'h0, 32'h0000_0023});
    for (k = 9; k >= 0; k--)
      cmd(plc_pkg::CMD_UNBLOCK_PIN, 8'h00, 8'h01, 8'h10,
        {xs() | 32'h1, xs(), xs(), xs()}, 16'h0000,
        16'h63C0 | 16'(k), 16'h0000);
    cmd(plc_pkg::CMD_UNBLOCK_PIN, 8'h00, 8'h01, 8'h10, {64'h0, xs(), xs()},
      16'h0000, plc_pkg::SW_BLOCKED, 16'h0000);
    cmd(plc_pkg::CMD_UNBLOCK_PIN, 8'h00, 8'h01, 8'h00, 128'h0, 16'h0000,
      plc_pkg::SW_BLOCKED, 16'h0000);
    axr(plc_pkg::REG_UNBLK_STAT, {2'h0, 32'h0000_0010});
    for (k = 0; k < 3; k++)
    begin
      cmd(plc_pkg::CMD_DEACTIVATE, modes[k], 8'h00, k ? 8'h04 : 8'h02, 128'h0,
        16'h2F01 + 16'(k), plc_pkg::SW_OK, 16'h2F01 + 16'(k));
      cmd(plc_pkg::CMD_ACTIVATE, 8'h00, 8'h00, 8'h00, 128'h0, 16'h0000,
        plc_pkg::SW_OK, 16'h2F01 + 16'(k));
    end
    cmd(plc_pkg::CMD_DEACTIVATE, 8'h00, 8'h00, 8'h02, 128'h0, 16'h2F01,
      plc_pkg::SW_OK, 16'h2F01);
    axr(plc_pkg::REG_FILE_STAT, {2'h0, 32'h2F01_0002});
    cmd(plc_pkg::CMD_OTHER, 8'h00, 8'h00, 8'h00, 128'h0, 16'h0000,
      plc_pkg::SW_FILE_INVALID, 16'h2F01);
    cmd(plc_pkg::CMD_DEACTIVATE, 8'h00, 8'h01, 8'h02, 128'h0, 16'h2F02,
      plc_pkg::SW_BAD_P1P2, 16'h2F01);
    cmd(plc_pkg::CMD_DEACTIVATE, 8'h02, 8'h00, 8'h02, 128'h0, 16'h2F02,
      plc_pkg::SW_BAD_P1P2, 16'h2F01);
    cmd(plc_pkg::CMD_DEACTIVATE, 8'h00, 8'h00, 8'h02, 128'h0, 16'h3F00,
      plc_pkg::SW_UNMAPPED, 16'h2F01);
    axw(plc_pkg::REG_CTRL, 32'h0000_0110, plc_pkg::RESP_OKAY);
    cmd(plc_pkg::CMD_ACTIVATE, 8'h00, 8'h00, 8'h00, 128'h0, 16'h0000,
      plc_pkg::SW_SEC_NOT_MET, 16'h2F01);
    axw(plc_pkg::REG_CTRL, 32'h0000_0120, plc_pkg::RESP_OKAY);
    cmd(plc_pkg::CMD_DEACTIVATE, 8'h00, 8'h00, 8'h02, 128'h0, 16'h2F02,
      plc_pkg::SW_SEC_NOT_MET, 16'h2F01);
    axw(plc_pkg::REG_CTRL, 32'h0000_0130, plc_pkg::RESP_OKAY);
    cmd(plc_pkg::CMD_ACTIVATE, 8'h00, 8'h00, 8'h00, 128'h0, 16'h0000,
      plc_pkg::SW_OK, 16'h2F01);
    axr(plc_pkg::REG_FILE_STAT, {2'h0, 32'h2F01_0000});
    repeat (5) @(posedge aclk);
    if (sq.size() != 0 || rq.size() != 0) bad("answers missing");
    close_out();
  end
endmodule
`default_nettype wire

// ==== verification/plc_cmd_core_assertions.sv ====
// port timing checker of the command handler, bound to its top module
`timescale 1ns/1ps
`default_nettype none
module plc_cmd_chk (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // command side
  input wire logic cmd_valid,
  input wire logic cmd_ready,
  input wire logic [2:0] cmd_code,
  input wire logic [7:0] cmd_p2,
  input wire logic [7:0] cmd_lc,
  input wire logic rsp_valid,
  input wire logic [15:0] rsp_sw,
  input wire logic se_revalidate,
  input wire logic [15:0] cur_ef,
  // register bus
  input wire logic s_axi_awready,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic take;
  assign take = cmd_valid && cmd_ready;
  ////////////////////////////////////////////////////////////////////////////
  a_ready_gap: assert property (
    take |=> !cmd_ready ##1 !cmd_ready ##1 cmd_ready)
    else $error("command ready gap wrong");
  a_answer_time: assert property (take |-> ##2 rsp_valid)
    else $error("answer not two cycles after take");
  a_pulse_once: assert property (rsp_valid |=> !rsp_valid)
    else $error("answer pulse too long");
  a_status_hold: assert property (!rsp_valid |-> $stable(rsp_sw))
    else $error("status word moved without answer");
  a_reval_ok: assert property (
    se_revalidate |-> rsp_valid && rsp_sw == plc_pkg::SW_OK)
    else $error("revalidation without success");
  a_sel_kept: assert property (
    rsp_valid && rsp_sw != plc_pkg::SW_OK |-> cur_ef == $past(cur_ef, 2))
    else $error("failed command moved current file");
  a_retry_word: assert property (
    take && cmd_code == plc_pkg::CMD_UNBLOCK_PIN && cmd_lc == 8'h00 &&
    cmd_p2 == 8'h01 |-> ##2
    (rsp_sw[15:4] == 12'h63C || rsp_sw == plc_pkg::SW_BLOCKED))
    else $error("empty unblock gave no retry count");
  a_bresp_stands: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped");
  a_read_stands: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped or moved");
  a_bus_refuse: assert property (
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while response pending");
endmodule
bind plc_cmd_core plc_cmd_chk u_chk (.aclk, .aresetn, .cmd_valid, .cmd_ready,
  .cmd_code, .cmd_p2, .cmd_lc, .rsp_valid, .rsp_sw, .se_revalidate, .cur_ef,
  .s_axi_awready, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_rdata,
  .s_axi_rvalid, .s_axi_rready);
`default_nettype wire

// ==== verification/plc_term.sv ====
// terminal model issuing command messages to the card
`timescale 1ns/1ps
`default_nettype none
module plc_term (
  // clock
  input wire logic aclk,
  // command request
  output logic cmd_valid,
  input wire logic cmd_ready,
  output logic [2:0] cmd_code,
  output logic [7:0] cmd_p1,
  output logic [7:0] cmd_p2,
  output logic [7:0] cmd_lc,
  output logic [127:0] cmd_data,
  output logic [15:0] cmd_file_id
);
  initial
  begin
    cmd_valid = 1'h0;
    cmd_code = 3'h0;
    cmd_p1 = 8'h00;
    cmd_p2 = 8'h00;
    cmd_lc = 8'h00;
    cmd_data = 128'h0;
    cmd_file_id = 16'h0000;
  end
  // gap + 1 idle cycles first, so a slow terminal is modelled as well as a prompt one
  task automatic send(input logic [2:0] c, input logic [7:0] p1, p2, lc,
    input logic [127:0] d, input logic [15:0] fid, input int gap,
    output bit ok);
    int i;
    ok = 1'b0;
    repeat (gap + 1) @(posedge aclk);
    cmd_valid <= 1'h1;
    cmd_code <= c;
    cmd_p1 <= p1;
    cmd_p2 <= p2;
    cmd_lc <= lc;
    cmd_data <= d;
    cmd_file_id <= fid;
    for (i = 0; i < 20; i++)
    begin
      @(posedge aclk);
      if (cmd_ready === 1'h1)
      begin
        ok = 1'b1;
        break;
      end
    end
    cmd_valid <= 1'h0;
    // released data and file id lines show the inverse, never the last value; code, p1, p2 and lc keep theirs
    cmd_data <= ~d;
    cmd_file_id <= ~fid;
  endtask
endmodule
`default_nettype wire
